/* File: hdl/tmrps_top.sv */
/*
  tmrps_top.sv: 8-bit event timer on an external count pin, with one 8-bit
  scaler shared between the timer (prescale) and the watchdog (postscale).
  assumes: count pin is asynchronous; core supplies config, writes and
  watchdog clear/tick pulses on clk_sys_i.
*/
// Operation
// RQ1 - unassigned scaler: count pin goes straight to the synchroniser input
// RQ2 - scaler output sampled on second and fourth phase ticks
// RQ3 - source holds pin high and low at least 2 osc periods plus 20 ns
// RQ4 - assigned to timer, scaler divides pin by a binary chain, symmetric output
// RQ5 - with scaler, pin period at least 4 osc plus 40 ns over ratio
// RQ6 - timer increments only after the sampled scaler output rises
// RQ7 - one 8-bit counter serves timer or watchdog, never both
// RQ8 - the party without the scaler runs unscaled
// RQ9 - assignment bit and 3-bit ratio form configuration bits 3:0
// RQ10 - timer write clears scaler while assigned to timer
// RQ11 - watchdog clear resets scaler while assigned to watchdog
// RQ12 - scaler count is neither readable nor loadable
// RQ13 - timer-write clear leaves assignment and ratio untouched
// RQ14 - watchdog ratios reach 1:128; the code reaches 1:256 at ratio 7
// RQ15 - each sampled rising edge adds one to the count, wrapping to zero
`timescale 1ns/10ps
`default_nettype none
`include "tmrps_regs.svh"

module tmrps_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // configuration and core accesses
  input wire tmrps_pkg::tmrps_cfg_t cfg_i,
  input wire logic count_wr_i,
  input wire logic [7:0] count_wdata_i,
  input wire logic kick_watchdog_instr_i,
  input wire logic watchdog_raw_tick_i,
  // external pin
  input wire logic ext_count_clock_pin_i,
  // results
  output logic [7:0] timer_count_reg_o,
  output logic watchdog_counter_tick_o,
  output logic second_phase_tick_o,
  output logic fourth_phase_tick_o
);

  tmrps_pkg::tmrps_state_t s_q;
  tmrps_pkg::tmrps_state_t s_d;
  logic to_timer;
  logic scaler_in;
  logic scaler_out;
  logic scaler_rise;
  logic pin_rise;
  logic [2:0] ratio;

  // ============================================================
  // scaler routing
  assign to_timer = ~cfg_i.scaler_assign_select; // see RQ7 see RQ9
  assign ratio = cfg_i.scaler_ratio_field;
  // scaler clocked by pin when it owns the timer, else by watchdog ticks
  // edge taken behind the synchroniser, never from its first flop
  assign pin_rise = s_q.pin_sync & ~s_q.pin_prev;
  assign scaler_in = to_timer ? pin_rise : watchdog_raw_tick_i; // see RQ8
  assign scaler_rise = s_q.scaler[ratio] & ~s_q.scaler_prev[ratio];
  // bypass: pin feeds sampler directly when scaler belongs to watchdog
  assign scaler_out = to_timer ? s_q.scaler[ratio] : s_q.pin_sync; // see RQ1 see RQ4

  // ============================================================
  // next state
  always_comb begin
    s_d = s_q;
    // phase counter, one enable pulse per phase of interest
    s_d.phase = (s_q.phase == `TMRPS_PHASES) ? 2'h0 : s_q.phase + 2'h1;
    s_d.second_phase_tick = (s_d.phase == 2'h1);
    s_d.fourth_phase_tick = (s_d.phase == 2'h3);
    // pin comes from outside, two flops first, third flop only for the edge
    s_d.pin_meta = ext_count_clock_pin_i;
    s_d.pin_sync = s_q.pin_meta;
    s_d.pin_prev = s_q.pin_sync;
    s_d.scaler_prev = s_q.scaler;
    // binary counter bits act as the ripple chain, bit k halves bit k-1
    if (scaler_in) begin
      s_d.scaler = s_q.scaler + 8'h01; // see RQ4
    end
    // the owner of the scaler gets the divided rate, the other the raw one
    if (!to_timer) begin
      // postscaled watchdog tick up to 1:256
      s_d.wd_tick = scaler_rise; // see RQ14
    end else begin
      s_d.wd_tick = watchdog_raw_tick_i; // see RQ8
    end
    // sample on phase 2 and phase 4 only
    if (s_q.second_phase_tick | s_q.fourth_phase_tick) begin
      s_d.sample = scaler_out; // see RQ2
      s_d.sample_prev = s_q.sample;
      if (s_q.sample & ~s_q.sample_prev) begin
        s_d.timer_count_reg = s_q.timer_count_reg + 8'h01; // see RQ6 see RQ15
      end
    end
    if (count_wr_i) begin
      s_d.timer_count_reg = count_wdata_i;
      if (to_timer) begin
        s_d.scaler = `TMRPS_SCALER_RESET; // see RQ10 see RQ13
      end
    end
    if (kick_watchdog_instr_i && !to_timer) begin
      s_d.scaler = `TMRPS_SCALER_RESET; // see RQ11
    end
  end

  // ============================================================
  // state register
  // scaler never leaves the module, no load path exists; see RQ12
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs, all straight from the state register
  // no output path is combinational, so the core sees clean levels
  assign timer_count_reg_o = s_q.timer_count_reg;
  assign watchdog_counter_tick_o = s_q.wd_tick;
  assign second_phase_tick_o = s_q.second_phase_tick;
  assign fourth_phase_tick_o = s_q.fourth_phase_tick;

  // ============================================================
  // checks
  // ============================================================
  // sequences shared by the properties
  sequence sq_sample_rise;
    (s_q.second_phase_tick | s_q.fourth_phase_tick) && s_q.sample && !s_q.sample_prev;
  endsequence

  sequence sq_second_then_fourth;
    !second_phase_tick_o ##1 fourth_phase_tick_o;
  endsequence

  sequence sq_fourth_then_second;
    !fourth_phase_tick_o ##1 second_phase_tick_o;
  endsequence

  sequence sq_count_at_max;
    timer_count_reg_o == 8'hFF && !count_wr_i;
  endsequence

  // ============================================================
  // timer count
  chk_count_incr: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ15
    sq_sample_rise and !count_wr_i |=> timer_count_reg_o == $past(timer_count_reg_o) + 8'h01)
    else $error("count did not advance by one");

  chk_count_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ6
    !(s_q.second_phase_tick | s_q.fourth_phase_tick) && !count_wr_i |=> $stable(timer_count_reg_o))
    else $error("count moved outside sampling phase");

  chk_count_wrap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ15
    sq_sample_rise ##0 sq_count_at_max |=> timer_count_reg_o == 8'h00)
    else $error("count did not wrap to zero");

  chk_write_load: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ13
    count_wr_i |=> timer_count_reg_o == $past(count_wdata_i))
    else $error("timer write lost");

  // ============================================================
  // shared scaler
  chk_write_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ10
    count_wr_i && !cfg_i.scaler_assign_select |=> s_q.scaler == 8'h00)
    else $error("timer write did not clear scaler");

  chk_kick_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ11
    kick_watchdog_instr_i && cfg_i.scaler_assign_select |=> s_q.scaler == 8'h00)
    else $error("watchdog clear did not clear scaler");

  chk_kick_refused: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ11
    kick_watchdog_instr_i && !cfg_i.scaler_assign_select && !count_wr_i && !pin_rise |=> $stable(s_q.scaler))
    else $error("watchdog clear touched timer scaler");

  chk_write_keep: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ10
    count_wr_i && cfg_i.scaler_assign_select && !kick_watchdog_instr_i && !watchdog_raw_tick_i
      |=> $stable(s_q.scaler))
    else $error("timer write touched watchdog scaler");

  chk_timer_owns: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ7
    !cfg_i.scaler_assign_select && watchdog_raw_tick_i && !pin_rise && !count_wr_i |=> $stable(s_q.scaler))
    else $error("watchdog tick moved timer scaler");

  chk_wd_owns: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ7
    cfg_i.scaler_assign_select && pin_rise && !watchdog_raw_tick_i && !kick_watchdog_instr_i
      |=> $stable(s_q.scaler))
    else $error("pin edge moved watchdog scaler");

  chk_scaler_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ4
    scaler_in && !count_wr_i && !kick_watchdog_instr_i |=> s_q.scaler == $past(s_q.scaler) + 8'h01)
    else $error("scaler did not step by one");

  // ============================================================
  // phases, sampling and watchdog tick
  chk_phase_ticks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ2
    second_phase_tick_o |=> sq_second_then_fourth)
    else $error("phase ticks out of order");

  chk_phase_alt: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ2
    fourth_phase_tick_o |=> sq_fourth_then_second)
    else $error("fourth tick not followed by second");

  chk_phase_period: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ2
    second_phase_tick_o |=> ##3 second_phase_tick_o)
    else $error("second tick period not four cycles");

  chk_sample_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ2
    !(s_q.second_phase_tick | s_q.fourth_phase_tick) |=> $stable(s_q.sample))
    else $error("sample changed off a phase tick");

  chk_bypass: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ1
    cfg_i.scaler_assign_select && s_q.second_phase_tick |=> s_q.sample == $past(s_q.pin_sync))
    else $error("pin bypass not sampled");

  chk_wdt_direct: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ8
    !cfg_i.scaler_assign_select |=> watchdog_counter_tick_o == $past(watchdog_raw_tick_i))
    else $error("watchdog not unscaled");

  chk_wd_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ14
    cfg_i.scaler_assign_select && !scaler_rise |=> !watchdog_counter_tick_o)
    else $error("watchdog tick without scaler edge");

endmodule : tmrps_top
`default_nettype wire

/* File: inc/tmrps_regs.svh */
/*
  tmrps_regs.svh: constants for the event timer and its shared scaler.
  assumes: included by bare name from the top-level design file; the package does not include it.
*/
`ifndef TMRPS_REGS_SVH
`define TMRPS_REGS_SVH

// ============================================================
// configuration field positions
`define TMRPS_CFG_RATIO_LSB 0
`define TMRPS_CFG_RATIO_MSB 2
`define TMRPS_CFG_ASSIGN_BIT 3

// ============================================================
// reset values
`define TMRPS_CFG_RESET 4'hF
`define TMRPS_COUNT_RESET 8'h00
`define TMRPS_SCALER_RESET 8'h00

// ============================================================
// timing
`define TMRPS_PHASES 2'h3
`define TMRPS_OSC_NS 100
`define TMRPS_MIN_HALF_NS (2 * `TMRPS_OSC_NS + 20)

`endif

/* File: inc/tmrps_pkg.sv */
/*
  tmrps_pkg.sv: types for the event timer and its shared scaler.
  assumes: nothing beyond the constants header.
*/
package tmrps_pkg;

  // ============================================================
  // configuration carrier
  typedef struct packed {
    logic scaler_assign_select;
    logic [2:0] scaler_ratio_field;
  } tmrps_cfg_t;

  // ============================================================
  // whole module state
  typedef struct packed {
    logic [1:0] phase;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [7:0] scaler;
    logic [7:0] scaler_prev;
    logic sample;
    logic sample_prev;
    logic [7:0] timer_count_reg;
    logic wd_tick;
    logic second_phase_tick;
    logic fourth_phase_tick;
  } tmrps_state_t;

endpackage : tmrps_pkg

/* File: verif/tmrps_pin_src.sv */
/*
  tmrps_pin_src.sv: model of the source that drives the external count pin.
  assumes: the bench calls send; clk is the 10 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tmrps_pin_src (
  // clock
  input wire logic clk_sys_i,
  // pin
  output logic ext_count_clock_pin_o
);
  // ============================================================
  // pulse train, pin rests low between bursts
  initial ext_count_clock_pin_o = 1'b0;
  // 300 ns per level: above the 220 ns floor and the scaled period floor
  task automatic send(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys_i);
      #1 ext_count_clock_pin_o = 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1 ext_count_clock_pin_o = 1'b0;
    end
  endtask : send
endmodule : tmrps_pin_src
`default_nettype wire

/* File: verif/test_tmrps_top.sv */
/*
  test_tmrps_top.sv: self-checking bench for the event timer and scaler.
  assumes: tmrps_top and tmrps_pin_src compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module test_tmrps_top;
  logic clk_sys_i;
  logic reset_n_i;
  tmrps_pkg::tmrps_cfg_t cfg;
  logic wr;
  logic [7:0] wdata;
  logic kick;
  logic raw_tick;
  logic pin;
  logic [7:0] count;
  logic wd_tick;
  logic q2;
  logic q4;
  logic [7:0] wd_seen;
  int failures;
  int cmp_count;
  tmrps_top u_tmrps_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cfg_i(cfg), .count_wr_i(wr),
    .count_wdata_i(wdata), .kick_watchdog_instr_i(kick), .watchdog_raw_tick_i(raw_tick),
    .ext_count_clock_pin_i(pin), .timer_count_reg_o(count), .watchdog_counter_tick_o(wd_tick),
    .second_phase_tick_o(q2), .fourth_phase_tick_o(q4));
  tmrps_pin_src u_tmrps_pin_src (.clk_sys_i(clk_sys_i), .ext_count_clock_pin_o(pin));
  // ============================================================
  // clock and monitors
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) wd_seen <= 8'h00;
    else if (wd_tick === 1'b1) wd_seen <= wd_seen + 8'h01;
  end
  // ============================================================
  // helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: tick got %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  task automatic write_count(input logic [7:0] v);
    wr = 1'b1;
    wdata = v;
    step(1);
    wr = 1'b0;
    step(1);
  endtask : write_count
  task automatic raw(input int n);
    repeat (n) begin
      raw_tick = 1'b1;
      step(1);
      raw_tick = 1'b0;
      step(3);
    end
  endtask : raw
  task automatic do_kick;
    kick = 1'b1;
    step(1);
    kick = 1'b0;
    step(1);
  endtask : do_kick
  // ============================================================
  // scenarios
  task automatic test_unscaled;
    cfg = 4'h8;
    write_count(8'hFD);
    u_tmrps_pin_src.send(5);
    step(12);
    chk8(count, 8'h02);
  endtask : test_unscaled
  task automatic test_prescale;
    logic [7:0] b;
    for (int n = 0; n < 4; n++) begin
      cfg = {1'b0, n[2:0]};
      b = wd_seen;
      raw(3);
      chk8(wd_seen, b + 8'h03);
      write_count(8'h10);
      u_tmrps_pin_src.send((1 << n) - 1);
      write_count(8'h20);
      u_tmrps_pin_src.send((1 << n) - 1);
      step(12);
      chk8(count, 8'h20);
      u_tmrps_pin_src.send(1 + (2 << n));
      step(12);
      chk8(count, 8'h22);
    end
  endtask : test_prescale
  task automatic test_watchdog;
    logic [7:0] b;
    cfg = 4'h9;
    do_kick();
    b = wd_seen;
    raw(1);
    do_kick();
    raw(1);
    chk8(wd_seen, b);
    write_count(8'h00);
    raw(1);
    chk8(wd_seen, b + 8'h01);
    cfg = 4'hE;
    do_kick();
    raw(63);
    chk8(wd_seen, b + 8'h01);
    raw(1);
    chk8(wd_seen, b + 8'h02);
  endtask : test_watchdog
  task automatic test_phases;
    while (q2 !== 1'b1) step(1);
    chk1(q4, 1'b0);
    step(1);
    chk1(q2 | q4, 1'b0);
    step(1);
    chk1(q4, 1'b1);
    step(2);
    chk1(q2, 1'b1);
  endtask : test_phases
  // ============================================================
  // run control
  task automatic complete_run;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
  initial begin
    {reset_n_i, wr, kick, raw_tick} = 4'h0;
    {cfg, wdata} = 12'h000;
    step(16);
    chk8(count, 8'h00);
    reset_n_i = 1'b1;
    step(2);
    test_phases();
    test_unscaled();
    test_prescale();
    test_watchdog();
    complete_run();
  end
endmodule : test_tmrps_top
`default_nettype wire
